// file: fbpio_checker.sv
`timescale 1ns/1ps

// Pin-level checks of the port block; everything here lives on the core clock.
module fbpio_checker
    import fbpio_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic arst_n,
    // Core side.
    input wire fbpio_req_s core_req,
    input wire fbpio_rsp_s core_rsp,
    input wire logic halt_exec,
    input wire logic standby_req,
    // Pad side.
    input wire logic [3:0] first_port_lines_in,
    input wire logic [3:0] first_port_lines_oe,
    input wire logic [3:0] second_port_lines_oe,
    input wire logic [3:0] second_port_lines_out,
    input wire logic [3:0] first_pullup_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // One request of a given kind aimed at a given port.
    sequence req_on(fbpio_op_e o, logic [1:0] p);
        core_req.op == o && core_req.port == p;
    endsequence
    // Standby line seen high long enough to pass the synchroniser, the last of those cycles a halt cycle.
    sequence line_high_halt;
        first_port_lines_in[3] [*5] ##0 halt_exec;
    endsequence

    wr_first_a: assert property (req_on(FBPIO_OP_WRITE, 2'h0) |=> first_port_lines_oe == ~$past(core_req.data))
        else $error("first port write not applied");
    set_second_a: assert property (req_on(FBPIO_OP_SET, 2'h1) |=>
        second_port_lines_oe == ($past(second_port_lines_oe) & ~(4'h1 << $past(core_req.bit_sel))))
        else $error("second port set touched wrong lines");
    clr_first_a: assert property (req_on(FBPIO_OP_CLEAR, 2'h0) |=>
        first_port_lines_oe == ($past(first_port_lines_oe) | (4'h1 << $past(core_req.bit_sel))))
        else $error("first port clear touched wrong lines");
    input_undriven_a: assert property (req_on(FBPIO_OP_WRITE, 2'h3) |=>
        $stable(first_port_lines_oe) && $stable(second_port_lines_oe))
        else $error("write to input port changed outputs");
    read_answer_a: assert property (core_req.op inside {FBPIO_OP_READ, FBPIO_OP_TEST} |=> core_rsp.valid)
        else $error("read or test not answered");
    no_spurious_a: assert property (!(core_req.op inside {FBPIO_OP_READ, FBPIO_OP_TEST}) |=> !core_rsp.valid)
        else $error("answer without a read");
    sink_only_a: assert property (second_port_lines_out == 4'h0 && first_pullup_en == ~first_port_lines_oe)
        else $error("pad drive or pull-up wrong");
    standby_on_a: assert property (line_high_halt |=> standby_req)
        else $error("standby not requested");
    standby_off_a: assert property (!halt_exec |=> !standby_req)
        else $error("standby without halt");
endmodule

bind fbpio_ports fbpio_checker u_chk (.core_clk(core_clk), .arst_n(arst_n), .core_req(core_req),
    .core_rsp(core_rsp), .halt_exec(halt_exec), .standby_req(standby_req),
    .first_port_lines_in(first_port_lines_in), .first_port_lines_oe(first_port_lines_oe),
    .second_port_lines_oe(second_port_lines_oe), .second_port_lines_out(second_port_lines_out),
    .first_pullup_en(first_pullup_en));

// file: fbpio_consts.svh
`ifndef FBPIO_CONSTS_SVH
`define FBPIO_CONSTS_SVH

// Port identifiers carried on the core request.
`define FBPIO_PORT_FIRST 2'h0
`define FBPIO_PORT_SECOND 2'h1
`define FBPIO_PORT_THIRD 2'h2
`define FBPIO_PORT_INPUT 2'h3

// Latch reset values for the output latches.
`define FBPIO_FIRST_RESET 4'hf
`define FBPIO_GROUP_HIGH 4'hf
`define FBPIO_GROUP_LOW 4'h0

// Position of the standby control line in the first port.
`define FBPIO_STANDBY_BIT 3

`endif

// file: fbpio_pins_model.sv
`timescale 1ns/1ps

// Outside world of one four-line port: switches that can only pull a line low.
module fbpio_pins_model (
    // Pad controls from the block.
    input wire logic [3:0] sink_on,
    input wire logic [3:0] pullup_on,
    // Closed switches and the resulting line levels.
    input wire logic [3:0] ext_low,
    output logic [3:0] level
);
    // A line reads high only when nobody sinks it and its pull-up holds it; a bare open-drain line is taken low.
    assign level = ~sink_on & ~ext_low & pullup_on;
endmodule

// file: fbpio_pkg.sv
package fbpio_pkg;

    // Operations the instruction core can request of the ports.
    typedef enum logic [5:0] {
        FBPIO_OP_NONE = 6'h01,
        FBPIO_OP_READ = 6'h02,
        FBPIO_OP_WRITE = 6'h04,
        FBPIO_OP_SET = 6'h08,
        FBPIO_OP_CLEAR = 6'h10,
        FBPIO_OP_TEST = 6'h20
    } fbpio_op_e;

    // One request from the core.
    typedef struct packed {
        fbpio_op_e op;
        logic [1:0] port;
        logic [1:0] bit_sel;
        logic [3:0] data;
    } fbpio_req_s;

    // One answer to the core.
    typedef struct packed {
        logic valid;
        logic [3:0] data;
        logic line_high;
    } fbpio_rsp_s;

endpackage

// file: fbpio_ports.sv
`timescale 1ns/1ps

// Behaviour
// - Nibble read and write of first port.
// - Bit tests and single-line set/clear.
// - First port top line also controls standby.
// - Second port same functions, no standby.
// - Second port reset level chosen per group.
// - Each line open-drain or pull-up by option.
// - Four input-only lines, never driven.
// - Input lines double as comparator inputs.
// - Third port behaves like the second.
module fbpio_ports
    import fbpio_pkg::*;
#(
    // Fixed mask options: a one selects pull-up, a zero open-drain.
    parameter logic [3:0] FIRST_PULLUP = 4'hf,
    parameter logic [3:0] SECOND_PULLUP = 4'hf,
    parameter logic [3:0] THIRD_PULLUP = 4'hf,
    // Group reset level options: one is high after reset.
    parameter logic SECOND_RESET_HIGH = 1'b1,
    parameter logic THIRD_RESET_HIGH = 1'b1,
    // One selects the comparator role for the input-only lines.
    parameter logic INPUT_AS_COMPARATOR = 1'b0
)
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic arst_n,
    // Core request and answer.
    input wire fbpio_req_s core_req,
    output fbpio_rsp_s core_rsp,
    // Halt from the core and resulting standby request.
    input wire logic halt_exec,
    output logic standby_req,
    // First port pins.
    input wire logic [3:0] first_port_lines_in,
    output logic [3:0] first_port_lines_out,
    output logic [3:0] first_port_lines_oe,
    // Second port pins.
    input wire logic [3:0] second_port_lines_in,
    output logic [3:0] second_port_lines_out,
    output logic [3:0] second_port_lines_oe,
    // Third port pins.
    input wire logic [3:0] third_port_lines_in,
    output logic [3:0] third_port_lines_out,
    output logic [3:0] third_port_lines_oe,
    // Input-only pins and comparator results.
    input wire logic [3:0] input_only_lines,
    input wire logic [3:0] comparator_lines,
    // Pull-up enables for the pad resistors.
    output logic [3:0] first_pullup_en,
    output logic [3:0] second_pullup_en,
    output logic [3:0] third_pullup_en
);
    `include "fbpio_consts.svh"

    // Reset copy, released two edges after the pin lets go.
    logic rst_s1_r;
    logic rst_n_r;

    // Output latches, one nibble per bidirectional port.
    logic [3:0] lat_r [3];
    logic [3:0] lat_nxt [3];

    // Registered answer to the core.
    fbpio_rsp_s rsp_r;
    fbpio_rsp_s rsp_nxt;

    // Standby request taken in the halt cycle.
    logic standby_r;
    logic standby_nxt;

    // Pin levels: raw per port, the input-only source, filtered per port, and the one a read selects.
    logic [3:0] pin_in [3];
    logic [3:0] input_src;
    logic [3:0] lvl [4];
    logic [3:0] sel_lvl;

    // Pad controls per port and the fixed pull-up masks behind them.
    logic [3:0] pullup_mask [3];
    logic [3:0] pad_oe [3];
    logic [3:0] pad_pu [3];

    // Reset release through two flops; assertion stays asynchronous.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // Gather pads and options into arrays so that one loop serves all three ports.
    assign pin_in[0] = first_port_lines_in;
    assign pin_in[1] = second_port_lines_in;
    assign pin_in[2] = third_port_lines_in;
    assign pullup_mask[0] = FIRST_PULLUP;
    assign pullup_mask[1] = SECOND_PULLUP;
    assign pullup_mask[2] = THIRD_PULLUP;

    // One synchroniser per port; the input-only port takes the comparator role by option.
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_port
            fbpio_sync u_sync (
                .core_clk(core_clk),
                .rst_n(rst_n_r),
                .pin_in(pin_in[p]),
                .level(lvl[p])
            );

            // Latches update on write, set or clear aimed at this port only.
            always_comb begin
                lat_nxt[p] = lat_r[p];
                if (core_req.port == 2'(p)) begin
                    unique case (core_req.op)
                        FBPIO_OP_WRITE: lat_nxt[p] = core_req.data;
                        FBPIO_OP_SET: lat_nxt[p][core_req.bit_sel] = 1'b1;
                        FBPIO_OP_CLEAR: lat_nxt[p][core_req.bit_sel] = 1'b0;
                        default: lat_nxt[p] = lat_r[p];
                    endcase
                end
            end
            // Reset values: the first port always high, the other two by their group option.
            always_ff @(posedge core_clk or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    lat_r[p] <= (p == 0) ? `FBPIO_FIRST_RESET
                        : ((p == 1) ? (SECOND_RESET_HIGH ? `FBPIO_GROUP_HIGH : `FBPIO_GROUP_LOW)
                        : (THIRD_RESET_HIGH ? `FBPIO_GROUP_HIGH : `FBPIO_GROUP_LOW));
                end else begin
                    lat_r[p] <= lat_nxt[p];
                end
            end

            // Per line, the sink is on while the latch is low and the pull-up only while it is high.
            always_comb begin
                pad_oe[p] = ~lat_r[p];
                pad_pu[p] = pullup_mask[p] & lat_r[p];
            end
        end
    endgenerate

    // The input-only group takes its plain pins or the comparator results, chosen once for all four lines.
    assign input_src = INPUT_AS_COMPARATOR ? comparator_lines : input_only_lines;

    // Fourth synchroniser for the input-only port; nothing in this block ever drives these lines.
    fbpio_sync u_sync_in (
        .core_clk(core_clk),
        .rst_n(rst_n_r),
        .pin_in(input_src),
        .level(lvl[3])
    );

    // Reads return pin levels, so a line held low by its own latch reads low.
    always_comb begin
        sel_lvl = lvl[core_req.port];
    end

    // Answer for read and test; one cycle after the request.
    always_comb begin
        rsp_nxt = '0;
        unique case (core_req.op)
            FBPIO_OP_READ: begin
                rsp_nxt.valid = 1'b1;
                rsp_nxt.data = sel_lvl;
            end
            FBPIO_OP_TEST: begin
                rsp_nxt.valid = 1'b1;
                rsp_nxt.line_high = sel_lvl[core_req.bit_sel];
            end
            default: rsp_nxt = '0;
        endcase
    end

    // Standby level is sampled during the halt cycle; the outside keeps it clean then.
    always_comb begin
        standby_nxt = standby_r;
        if (halt_exec) begin
            standby_nxt = lvl[0][`FBPIO_STANDBY_BIT];
        end else begin
            standby_nxt = 1'b0;
        end
    end

    // Answer register; a read answer stands for exactly one cycle.
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    // Standby register; it drops again in the first cycle without a halt.
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            standby_r <= 1'b0;
        end else begin
            standby_r <= standby_nxt;
        end
    end

    // Open-drain pads only ever sink, so the data lines stay low and the enables carry the value.
    always_comb begin
        first_port_lines_out = 4'h0;
        second_port_lines_out = 4'h0;
        third_port_lines_out = 4'h0;
        first_port_lines_oe = pad_oe[0];
        second_port_lines_oe = pad_oe[1];
        third_port_lines_oe = pad_oe[2];
        first_pullup_en = pad_pu[0];
        second_pullup_en = pad_pu[1];
        third_pullup_en = pad_pu[2];
    end

    assign core_rsp = rsp_r;
    assign standby_req = standby_r;
endmodule

// file: fbpio_sync.sv
`timescale 1ns/1ps

// Three-stage synchroniser for one nibble of pin levels; a change is accepted once stages two and three agree.
module fbpio_sync
    import fbpio_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Pin levels and filtered result.
    input wire logic [3:0] pin_in,
    output logic [3:0] level
);
    `include "fbpio_consts.svh"

    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;
    logic [3:0] level_r;
    logic [3:0] level_nxt;

    // Per bit, accept the new level only when the two later stages match.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_bit
            always_comb begin
                level_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : level_r[g];
            end
        end
    endgenerate

    // Released lines float high through the pull-up, so reset to high.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 4'hf;
            s2_r <= 4'hf;
            s3_r <= 4'hf;
            level_r <= 4'hf;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign level = level_r;
endmodule

// file: four_bit_parallel_io_ports_tb_top.sv
`timescale 1ns/1ps

module four_bit_parallel_io_ports_tb_top
    import fbpio_pkg::*;
;
    logic core_clk;
    logic arst_n = 1'b0;
    logic halt_exec = 1'b0;
    logic standby;
    fbpio_req_s req = '{FBPIO_OP_NONE, 2'h0, 2'h0, 4'h0};
    fbpio_rsp_s rsp;
    logic [3:0] pin [3];
    logic [3:0] oe [3];
    logic [3:0] pu [3];
    logic [3:0] ext [3] = '{4'h0, 4'h0, 4'h0};
    logic [3:0] in_only = 4'h0;
    logic [3:0] cmp_in = 4'h0;
    fbpio_rsp_s rsp_alt;
    logic [3:0] oe_alt [3];
    logic [3:0] pu_alt [3];
    int err_count = 0;
    int checked = 0;

    fbpio_ports u_dut (.core_clk(core_clk), .arst_n(arst_n), .core_req(req), .core_rsp(rsp),
        .halt_exec(halt_exec), .standby_req(standby),
        .first_port_lines_in(pin[0]), .first_port_lines_out(), .first_port_lines_oe(oe[0]),
        .second_port_lines_in(pin[1]), .second_port_lines_out(), .second_port_lines_oe(oe[1]),
        .third_port_lines_in(pin[2]), .third_port_lines_out(), .third_port_lines_oe(oe[2]),
        .input_only_lines(in_only), .comparator_lines(cmp_in),
        .first_pullup_en(pu[0]), .second_pullup_en(pu[1]), .third_pullup_en(pu[2]));

    // A second build with the other options: comparator role, second port low after reset, part pull-ups.
    fbpio_ports #(.THIRD_PULLUP(4'h5), .SECOND_RESET_HIGH(1'b0), .INPUT_AS_COMPARATOR(1'b1)) u_dut_cmp (
        .core_clk(core_clk), .arst_n(arst_n), .core_req(req), .core_rsp(rsp_alt),
        .halt_exec(halt_exec), .standby_req(),
        .first_port_lines_in(pin[0]), .first_port_lines_out(), .first_port_lines_oe(oe_alt[0]),
        .second_port_lines_in(pin[1]), .second_port_lines_out(), .second_port_lines_oe(oe_alt[1]),
        .third_port_lines_in(pin[2]), .third_port_lines_out(), .third_port_lines_oe(oe_alt[2]),
        .input_only_lines(in_only), .comparator_lines(cmp_in),
        .first_pullup_en(pu_alt[0]), .second_pullup_en(pu_alt[1]), .third_pullup_en(pu_alt[2]));

    // One outside model per bidirectional port.
    for (genvar g = 0; g < 3; g++) begin : g_pins
        fbpio_pins_model u_pins (.sink_on(oe[g]), .pullup_on(pu[g]), .ext_low(ext[g]), .level(pin[g]));
    end

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Holds a request for one edge; returns just after the edge that registers its answer.
    task automatic issue(input fbpio_op_e op, input logic [1:0] p, input logic [1:0] b, input logic [3:0] d);
        @(posedge core_clk);
        req <= '{op, p, b, d};
        @(posedge core_clk);
        req <= '{FBPIO_OP_NONE, 2'h0, 2'h0, 4'h0};
        #1;
    endtask

    task automatic t_reset();
        for (int p = 0; p < 3; p++) begin
            chk(oe[p], 4'h0);
            chk(pu[p], 4'hf);
        end
        chk(oe_alt[0], 4'h0);
        chk(oe_alt[1], 4'hf);
        chk(pu_alt[1], 4'h0);
        chk(oe_alt[2], 4'h0);
        chk(pu_alt[2], 4'h5);
    endtask

    // Nibble write, single-line set and clear, then read back pin levels with one line pulled low outside.
    task automatic t_ports();
        for (int p = 0; p < 3; p++) begin
            issue(FBPIO_OP_WRITE, p[1:0], 2'h0, 4'h6);
            chk(oe[p], 4'h9);
            issue(FBPIO_OP_SET, p[1:0], 2'h0, 4'h0);
            chk(oe[p], 4'h8);
            issue(FBPIO_OP_CLEAR, p[1:0], 2'h2, 4'h0);
            chk(oe[p], 4'hc);
            chk(pu[p], 4'h3);
            @(posedge core_clk) ext[p] <= 4'h1;
            repeat (6) @(posedge core_clk);
            issue(FBPIO_OP_READ, p[1:0], 2'h0, 4'h0);
            chk(rsp.data, 4'h2);
            chk({3'h0, rsp.valid}, 4'h1);
            issue(FBPIO_OP_TEST, p[1:0], 2'h1, 4'h0);
            chk({3'h0, rsp.line_high}, 4'h1);
            issue(FBPIO_OP_TEST, p[1:0], 2'h0, 4'h0);
            chk({3'h0, rsp.line_high}, 4'h0);
        end
    endtask

    // Input-only port is read and bit-tested in both roles, but a write to it changes nothing.
    task automatic t_input();
        @(posedge core_clk);
        in_only <= 4'ha;
        cmp_in <= 4'h5;
        repeat (6) @(posedge core_clk);
        issue(FBPIO_OP_READ, 2'h3, 2'h0, 4'h0);
        chk(rsp.data, 4'ha);
        chk(rsp_alt.data, 4'h5);
        issue(FBPIO_OP_TEST, 2'h3, 2'h2, 4'h0);
        chk({3'h0, rsp.line_high}, 4'h0);
        chk({3'h0, rsp_alt.line_high}, 4'h1);
        issue(FBPIO_OP_WRITE, 2'h3, 2'h0, 4'h0);
        for (int p = 0; p < 3; p++) begin
            chk(oe[p], 4'hc);
        end
    endtask

    // The outside keeps the standby line steady across each halt cycle.
    task automatic t_standby(input logic [3:0] pull, input logic [3:0] exp);
        issue(FBPIO_OP_WRITE, 2'h0, 2'h0, 4'hf);
        @(posedge core_clk) ext[0] <= pull;
        repeat (6) @(posedge core_clk);
        halt_exec <= 1'b1;
        @(posedge core_clk);
        halt_exec <= 1'b0;
        #1;
        chk({3'h0, standby}, exp);
        @(posedge core_clk);
        #1;
        chk({3'h0, standby}, 4'h0);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // The whole run is about 130 cycles, so this bound only trips on a hang.
    initial begin
        #20000;
        err_count++;
        finish_test();
    end

    initial begin
        repeat (16) @(posedge core_clk);
        t_reset();
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_ports();
        t_input();
        t_standby(4'h0, 4'h1);
        t_standby(4'h8, 4'h0);
        // A second reset in mid-run must bring every latch back and leave the block usable.
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_reset();
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_standby(4'h0, 4'h1);
        finish_test();
    end
endmodule
